// [shared/fdas_pkg.sv]
/*
 Constants, encodings and register map of the fieldbus DIP address select block.
 Assumes a 10 MHz system clock and a classic Wishbone slave port of 32 bits.
*/
//------------------------------------------------------------
// Behaviour
// RULE1: Local address is binary sum of switches 1-7, weights 1..64.
// RULE2: Switch 8 off selects bus-set address; on selects switch address.
// RULE3: Address-mode switch is sampled once at power-up only.
// RULE4: Local-mode address stays fixed; every change attempt is refused.
// RULE5: Bus mode uses the station address held in nonvolatile memory.
// RULE6: Stored station address is 126 when shipped.
// RULE7: Bus mode accepts new address from bus or keypad and stores it.
// RULE8: Selector picks one of three function-block sets.
// RULE9: Selector written only acyclically; cyclic writes are rejected.
// RULE10: Other variant: switch 1 on enables analog input simulation.
// RULE11: Other variant: switch 2 on locks all bus writes; code locks selector writes only, status flag clears still go through.
// RULE12: Other variant: switches 3 to 10 have no effect; code still loads switches 1-7 as address when switch 8 is on.
// RULE13: Other variant: device reports manufacturer, device and serial codes.
// RULE14: Valid station address is 0 to 125.
// RULE15: Switches are synchronised, debounced, sampled once and held.
//------------------------------------------------------------
package fdas_pkg;

   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int DEB_MS = 5;
   localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);

   // Switch bank
   localparam int NSW = 10;
   localparam int SW_MODE = 7;
   localparam int SW_SIM = 0;
   localparam int SW_WLOCK = 1;

   // Addresses
   localparam logic [6:0] SHIPPED_ADDR = 7'h7E;
   localparam logic [7:0] MAX_ADDR = 8'h7D;

   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_ADDR = 8'h04;
   localparam logic [7:0] OFS_BSET = 8'h08;
   localparam logic [7:0] OFS_SWITCH = 8'h0C;
   localparam logic [7:0] OFS_MFR = 8'h10;
   localparam logic [7:0] OFS_DEV = 8'h14;
   localparam logic [7:0] OFS_SERIAL = 8'h18;

   // Status bits
   localparam int ST_RUN = 0;
   localparam int ST_LOCAL = 1;
   localparam int ST_VARIANT = 2;
   localparam int ST_SIM = 3;
   localparam int ST_WLOCK = 4;
   localparam int ST_SELREJ = 5;
   localparam int ST_ADRREJ = 6;

   // Identity defaults, values arbitrary
   localparam logic [31:0] MFR_ID_DEF = 32'h0000_00A5;
   localparam logic [31:0] DEV_ID_DEF = 32'h0000_005A;
   localparam logic [31:0] SERIAL_DEF = 32'h0000_0001;

   typedef enum logic [1:0] {
      BS_ANALOG_INPUT_BLOCK = 2'b00,
      BS_ONE_TOTALIZER_BLOCK = 2'b01,
      BS_FULL = 2'b10
   } fdas_bset_type;

   localparam fdas_bset_type BSET_RST = BS_FULL;

   typedef enum logic [1:0] {
      S_SETTLE = 2'b00,
      S_SAMPLE = 2'b01,
      S_RUN = 2'b10
   } fdas_state_type;

endpackage

// [hdl/fdas_debounce.sv]
/*
 Per-bit synchroniser and debouncer for the switch bank.
 Assumes switch levels may change at any time relative to clk_i.
*/
`timescale 1ns/10ps
module fdas_debounce #(
   parameter int N = 10,
   parameter int CNT = 50000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N-1:0] raw_i,
   output logic [N-1:0] val_o,
   output logic settled_o
);
   localparam int CW = $clog2(CNT + 1);
   localparam logic [CW-1:0] LAST = CW'(CNT - 1);

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] prev;
      logic [N-1:0] val;
      logic [N-1:0] done;
      logic [N-1:0][CW-1:0] cnt;
   } fdas_deb_type;

   fdas_deb_type r_ff;
   fdas_deb_type nxt_r;

   //------------------------------------------------------------
   // Filter
   //------------------------------------------------------------
   // First stage feeds only the second stage
   always_comb begin
      nxt_r = r_ff;
      nxt_r.s1 = raw_i;
      nxt_r.s2 = r_ff.s1;
      nxt_r.prev = r_ff.s2;
      for (int i = 0; i < N; i++) begin
         if (r_ff.s2[i] != r_ff.prev[i]) begin
            nxt_r.cnt[i] = '0;
         end else if (r_ff.cnt[i] == LAST) begin
            nxt_r.val[i] = r_ff.s2[i]; // see RULE15
            nxt_r.done[i] = 1'b1;
         end else begin
            nxt_r.cnt[i] = r_ff.cnt[i] + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign val_o = r_ff.val;
   assign settled_o = &r_ff.done;

endmodule

// [hdl/fdas_top.sv]
/*
 Power-up switch sampling, station address selection, block-set selector
 and switch options of a fieldbus front end, with a Wishbone register port.
 Assumes rst_i is asserted at power-up and that a nonvolatile store
 presents its saved address on nvm_addr_i and accepts nvm_wr_o pulses.
*/
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module fdas_top #(
   parameter int DEB_CYC = fdas_pkg::DEB_CYC,
   parameter logic [31:0] MFR_ID = fdas_pkg::MFR_ID_DEF,
   parameter logic [31:0] DEV_ID = fdas_pkg::DEV_ID_DEF,
   parameter logic [31:0] SERIAL = fdas_pkg::SERIAL_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Switches and variant strap
   input wire logic [fdas_pkg::NSW-1:0] dip_i,
   input wire logic fnd_variant_i,
   // Keypad address entry
   input wire logic key_stb_i,
   input wire logic [7:0] key_addr_i,
   // Cyclic write attempt on the selector
   input wire logic cyc_sel_stb_i,
   input wire logic [1:0] cyc_sel_i,
   // Nonvolatile store
   input wire logic [6:0] nvm_addr_i,
   output logic nvm_wr_o,
   output logic [6:0] nvm_wdata_o,
   // Results
   output logic config_done_o,
   output logic [6:0] station_addr_o,
   output logic addr_valid_o,
   output logic [1:0] block_set_o,
   output logic sim_enable_o,
   output logic write_lock_o
);

   typedef struct packed {
      fdas_pkg::fdas_state_type state;
      logic [fdas_pkg::NSW-1:0] sw;
      logic local_mode;
      logic variant;
      logic sim;
      logic wlock;
      logic [6:0] addr;
      logic addr_valid;
      fdas_pkg::fdas_bset_type bset;
      logic sel_rej;
      logic adr_rej;
      logic nvm_wr;
      logic [6:0] nvm_data;
      logic ack;
      logic [31:0] dat;
   } fdas_top_type;

   fdas_top_type r_ff;
   fdas_top_type nxt_r;

   logic [fdas_pkg::NSW-1:0] sw_deb;
   logic settled;
   logic wb_req;
   logic wr_go;
   logic run;
   logic bus_mode;
   logic [7:0] new_addr;
   logic take_addr;
   logic [31:0] status;

   fdas_debounce #(
      .N(fdas_pkg::NSW),
      .CNT(DEB_CYC)
   ) u_deb (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .raw_i(dip_i),
      .val_o(sw_deb),
      .settled_o(settled)
   );

   //------------------------------------------------------------
   // Bus handshake
   //------------------------------------------------------------
   // Write commits on the edge where the master sees ack
   assign wb_req = cyc_i & stb_i & ~r_ff.ack;
   assign wr_go = cyc_i & stb_i & we_i & r_ff.ack & sel_i[0];
   assign run = r_ff.state == fdas_pkg::S_RUN;
   assign bus_mode = run & ~r_ff.variant & ~r_ff.local_mode;

   assign status = {25'h0000000, r_ff.adr_rej, r_ff.sel_rej, r_ff.wlock,
                    r_ff.sim, r_ff.variant, r_ff.local_mode, run};

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      nxt_r.ack = wb_req;
      nxt_r.nvm_wr = 1'b0;
      new_addr = 8'h00;
      take_addr = 1'b0;

      case (r_ff.state)
         fdas_pkg::S_SETTLE: begin
            if (settled) begin
               nxt_r.state = fdas_pkg::S_SAMPLE;
            end
         end
         fdas_pkg::S_SAMPLE: begin
            // Only sample ever taken; later switch moves are ignored
            nxt_r.sw = sw_deb; // see RULE15
            nxt_r.variant = fnd_variant_i;
            nxt_r.local_mode = sw_deb[fdas_pkg::SW_MODE] & ~fnd_variant_i; // see RULE3
            // Switches 3..10 set no option in the other variant; switch 8 still picks the switch address
            nxt_r.sim = fnd_variant_i & sw_deb[fdas_pkg::SW_SIM]; // see RULE10
            nxt_r.wlock = fnd_variant_i & sw_deb[fdas_pkg::SW_WLOCK]; // see RULE11 RULE12
            if (sw_deb[fdas_pkg::SW_MODE]) begin
               nxt_r.addr = sw_deb[6:0]; // see RULE1 RULE2
            end else begin
               nxt_r.addr = nvm_addr_i; // see RULE2 RULE5
            end
            nxt_r.state = fdas_pkg::S_RUN;
         end
         fdas_pkg::S_RUN: begin
            nxt_r.state = fdas_pkg::S_RUN;
         end
         default: begin
            nxt_r.state = fdas_pkg::S_SETTLE;
         end
      endcase

      // Status flags clear first so a same-cycle event still sets them
      if (wr_go && adr_i == fdas_pkg::OFS_STATUS) begin
         if (dat_i[fdas_pkg::ST_SELREJ]) begin
            nxt_r.sel_rej = 1'b0;
         end
         if (dat_i[fdas_pkg::ST_ADRREJ]) begin
            nxt_r.adr_rej = 1'b0;
         end
      end

      // Keypad has priority over a bus write in the same cycle
      if (key_stb_i) begin
         new_addr = key_addr_i;
         take_addr = 1'b1;
      end else if (wr_go && adr_i == fdas_pkg::OFS_ADDR) begin
         new_addr = dat_i[7:0];
         take_addr = 1'b1;
      end
      if (take_addr) begin
         if (bus_mode && new_addr <= fdas_pkg::MAX_ADDR) begin
            nxt_r.addr = new_addr[6:0]; // see RULE7 RULE14
            nxt_r.nvm_wr = 1'b1;
            nxt_r.nvm_data = new_addr[6:0];
         end else begin
            nxt_r.adr_rej = 1'b1; // see RULE4 RULE14
         end
      end

      if (wr_go && adr_i == fdas_pkg::OFS_BSET) begin
         if (r_ff.wlock || dat_i[1:0] == 2'b11) begin
            nxt_r.sel_rej = 1'b1; // see RULE11
         end else begin
            nxt_r.bset = fdas_pkg::fdas_bset_type'(dat_i[1:0]); // see RULE8 RULE9
         end
      end

      // Cyclic exchange may never alter the selector
      if (cyc_sel_stb_i) begin
         nxt_r.sel_rej = 1'b1; // see RULE9
      end

      nxt_r.addr_valid = (nxt_r.state == fdas_pkg::S_RUN) & ~nxt_r.variant
                         & ({1'b0, nxt_r.addr} <= fdas_pkg::MAX_ADDR); // see RULE14

      // Read data, unmapped offsets answer zero
      if (wb_req && !we_i) begin
         if (adr_i == fdas_pkg::OFS_STATUS) begin
            nxt_r.dat = status;
         end else if (adr_i == fdas_pkg::OFS_ADDR) begin
            nxt_r.dat = {25'h0000000, r_ff.addr};
         end else if (adr_i == fdas_pkg::OFS_BSET) begin
            nxt_r.dat = {30'h00000000, r_ff.bset};
         end else if (adr_i == fdas_pkg::OFS_SWITCH) begin
            nxt_r.dat = {22'h000000, r_ff.sw};
         end else if (adr_i == fdas_pkg::OFS_MFR) begin
            nxt_r.dat = MFR_ID; // see RULE13
         end else if (adr_i == fdas_pkg::OFS_DEV) begin
            nxt_r.dat = DEV_ID;
         end else if (adr_i == fdas_pkg::OFS_SERIAL) begin
            nxt_r.dat = SERIAL;
         end else begin
            nxt_r.dat = 32'h00000000;
         end
      end
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_ff <= '0;
         r_ff.addr <= fdas_pkg::SHIPPED_ADDR; // see RULE6
         r_ff.bset <= fdas_pkg::BSET_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign dat_o = r_ff.dat;
   assign ack_o = r_ff.ack;
   assign nvm_wr_o = r_ff.nvm_wr;
   assign nvm_wdata_o = r_ff.nvm_data;
   assign config_done_o = run;
   assign station_addr_o = r_ff.addr;
   assign addr_valid_o = r_ff.addr_valid;
   assign block_set_o = r_ff.bset;
   assign sim_enable_o = r_ff.sim;
   assign write_lock_o = r_ff.wlock;

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_sample;
      r_ff.state == fdas_pkg::S_SAMPLE;
   endsequence

   sequence s_running;
      r_ff.state == fdas_pkg::S_RUN;
   endsequence

   a_local_addr_sum: assert property ( // see RULE1
      s_running ##0 r_ff.local_mode |-> station_addr_o == r_ff.sw[6:0])
      else $error("local address differs from switch sum");

   a_mode_select: assert property ( // see RULE2
      s_sample |=> r_ff.local_mode == ($past(sw_deb[fdas_pkg::SW_MODE])
                                       & ~$past(fnd_variant_i)))
      else $error("address mode not taken from switch 8");

   a_mode_held: assert property ( // see RULE3
      s_running |=> $stable(r_ff.local_mode) && $stable(r_ff.sw))
      else $error("sampled switches changed in operation");

   a_local_fixed: assert property ( // see RULE4
      s_running ##0 r_ff.local_mode |=> $stable(station_addr_o) && !nvm_wr_o)
      else $error("local address changed");

   a_bus_nvm_addr: assert property ( // see RULE5
      s_sample ##0 !sw_deb[fdas_pkg::SW_MODE] |=> station_addr_o == $past(nvm_addr_i))
      else $error("bus mode address not from store");

   a_key_store: assert property ( // see RULE7
      bus_mode && key_stb_i && key_addr_i <= fdas_pkg::MAX_ADDR
      |=> nvm_wr_o && nvm_wdata_o == $past(key_addr_i[6:0])
          ##1 !nvm_wr_o)
      else $error("keypad address not stored");

   a_cyclic_reject: assert property ( // see RULE9
      cyc_sel_stb_i && !(wr_go && adr_i == fdas_pkg::OFS_BSET)
      |=> r_ff.sel_rej && $stable(block_set_o))
      else $error("cyclic selector write not rejected");

   a_sim_switch: assert property ( // see RULE10
      s_running |-> sim_enable_o == (r_ff.variant & r_ff.sw[fdas_pkg::SW_SIM]))
      else $error("simulation enable wrong");

   a_write_lock: assert property ( // see RULE11
      write_lock_o && wr_go && adr_i == fdas_pkg::OFS_BSET
      |=> $stable(block_set_o) && r_ff.sel_rej)
      else $error("locked selector write went through");

   a_addr_range: assert property ( // see RULE14
      s_running ##0 key_stb_i && key_addr_i > fdas_pkg::MAX_ADDR
      |=> $stable(station_addr_o) && !nvm_wr_o)
      else $error("out of range address accepted");

endmodule

// [test/fdas_nvm_model.sv]
/*
 Nonvolatile station address store standing beside the block.
 Assumes one-cycle write pulses on clk_i; content survives resets.
*/
`timescale 1ns/10ps
module fdas_nvm_model (
   input wire logic clk_i,
   input wire logic wr_i,
   input wire logic [6:0] wdata_i,
   output logic [6:0] addr_o
);
   // Shipped content, kept across resets like real storage
   initial addr_o = 7'h7E;
   always @(posedge clk_i) begin
      if (wr_i === 1'b1) begin
         addr_o <= wdata_i;
      end
   end
endmodule

// [test/test_fieldbus_dip_address_select.sv]
/*
 Self-checking bench for the fieldbus DIP address select block.
 Assumes the store model keeps its value across power cycles.
*/
`timescale 1ns/10ps
module test_fieldbus_dip_address_select;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [9:0] dip_i = 10'h000;
   logic fnd_variant_i = 1'b0;
   logic key_stb_i = 1'b0;
   logic [7:0] key_addr_i = 8'h00;
   logic cyc_sel_stb_i = 1'b0;
   logic [1:0] cyc_sel_i = 2'h0;
   logic [31:0] dat_o;
   logic ack_o, nvm_wr_o, config_done_o, addr_valid_o, sim_enable_o, write_lock_o;
   logic [6:0] nvm_addr_i, nvm_wdata_o, station_addr_o;
   logic [1:0] block_set_o;
   logic [31:0] rdata;
   logic [9:0] sw;
   int n_mismatch = 0;
   int num_checks = 0;
   int exp_wr[$];
   int r, k, b;

   always #50 clk_i = ~clk_i;

   // Short debounce keeps the power-up sample quick
   fdas_top #(.DEB_CYC(4)) u_fdas_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .dip_i(dip_i), .fnd_variant_i(fnd_variant_i),
      .key_stb_i(key_stb_i), .key_addr_i(key_addr_i), .cyc_sel_stb_i(cyc_sel_stb_i),
      .cyc_sel_i(cyc_sel_i), .nvm_addr_i(nvm_addr_i), .nvm_wr_o(nvm_wr_o),
      .nvm_wdata_o(nvm_wdata_o), .config_done_o(config_done_o),
      .station_addr_o(station_addr_o), .addr_valid_o(addr_valid_o),
      .block_set_o(block_set_o), .sim_enable_o(sim_enable_o),
      .write_lock_o(write_lock_o));
   fdas_nvm_model u_fdas_nvm_model (.clk_i(clk_i), .wr_i(nvm_wr_o),
      .wdata_i(nvm_wdata_o), .addr_o(nvm_addr_i));

   //------------------------------------------------------------
   // Tasks
   //------------------------------------------------------------
   task end_of_test;
      if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task stop_hung;
      n_mismatch++;
      $display("Error at %0t: wait timed out", $time);
      end_of_test();
   endtask

   // Held until ack is sampled; data taken on that same edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack_o !== 1'b1 && i < 20);
      if (ack_o !== 1'b1) stop_hung();
      rdata = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   task key(input logic [7:0] v);
      key_stb_i <= 1'b1;
      key_addr_i <= v;
      @(posedge clk_i);
      key_stb_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   task power_up(input logic vr, input logic [9:0] s);
      int i;
      rst_i <= 1'b1;
      fnd_variant_i <= vr;
      dip_i <= s;
      repeat (10) @(posedge clk_i);
      chk(32'(station_addr_o), 32'(fdas_pkg::SHIPPED_ADDR));
      chk(32'(block_set_o), 32'(fdas_pkg::BSET_RST));
      rst_i <= 1'b0;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (config_done_o !== 1'b1 && i < 100);
      if (config_done_o !== 1'b1) stop_hung();
      repeat (2) @(posedge clk_i);
   endtask

   // Every store write must be one the bench expects
   always @(posedge clk_i) begin
      if (nvm_wr_o === 1'b1) begin
         if (exp_wr.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(nvm_wdata_o), 32'(exp_wr.pop_front()));
      end
   end

   //------------------------------------------------------------
   // Sequence
   //------------------------------------------------------------
   initial begin
      void'($urandom(86));
      sw = 10'($urandom);
      sw[7] = 1'b0;
      power_up(1'b0, sw);
      chk(32'(station_addr_o), 32'h7E);
      chk(32'(addr_valid_o), 32'h0);
      wb(1'b0, fdas_pkg::OFS_STATUS, 32'h0);
      chk(rdata & 32'h7, 32'h1);
      dip_i <= 10'h3FF;
      exp_wr.push_back(5);
      key(8'h05);
      chk(32'(station_addr_o), 32'h5);
      wb(1'b0, fdas_pkg::OFS_SWITCH, 32'h0);
      chk(rdata, 32'(sw));
      r = $urandom_range(125);
      exp_wr.push_back(r);
      wb(1'b1, fdas_pkg::OFS_ADDR, 32'(r));
      chk(32'(station_addr_o), 32'(r));
      chk(32'(addr_valid_o), 32'h1);
      wb(1'b1, fdas_pkg::OFS_ADDR, 32'h7E);
      key(8'h80);
      chk(32'(station_addr_o), 32'(r));
      wb(1'b0, fdas_pkg::OFS_STATUS, 32'h0);
      chk(rdata & 32'h42, 32'h40);
      b = 2;
      for (k = 0; k < 4; k++) begin
         wb(1'b1, fdas_pkg::OFS_BSET, 32'(k));
         if (k < 3) b = k;
         wb(1'b0, fdas_pkg::OFS_BSET, 32'h0);
         chk(rdata, 32'(b));
         chk(32'(block_set_o), 32'(b));
      end
      wb(1'b1, fdas_pkg::OFS_STATUS, 32'h60);
      cyc_sel_i <= 2'($urandom);
      cyc_sel_stb_i <= 1'b1;
      @(posedge clk_i);
      cyc_sel_stb_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(block_set_o), 32'(b));
      wb(1'b0, fdas_pkg::OFS_STATUS, 32'h0);
      chk(rdata & 32'h60, 32'h20);
      wb(1'b0, 8'hFC, 32'h0);
      chk(rdata, 32'h0);
      // Local addressing: switch value fixed, changes refused
      sw = 10'($urandom);
      sw[7] = 1'b1;
      power_up(1'b0, sw);
      chk(32'(station_addr_o), 32'(sw[6:0]));
      chk(32'(addr_valid_o), 32'(sw[6:0] <= 7'h7D));
      key(8'h03);
      wb(1'b1, fdas_pkg::OFS_ADDR, 32'h9);
      chk(32'(station_addr_o), 32'(sw[6:0]));
      wb(1'b0, fdas_pkg::OFS_STATUS, 32'h0);
      chk(rdata & 32'h42, 32'h42);
      // Other variant, both option switch settings
      for (k = 0; k < 2; k++) begin
         sw = 10'($urandom);
         sw[1:0] = k[0] ? 2'b10 : 2'b01;
         power_up(1'b1, sw);
         chk(32'(sim_enable_o), 32'(sw[0]));
         chk(32'(write_lock_o), 32'(sw[1]));
         wb(1'b1, fdas_pkg::OFS_BSET, 32'h0);
         chk(32'(block_set_o), sw[1] ? 32'h2 : 32'h0);
         chk(32'(addr_valid_o), 32'h0);
      end
      wb(1'b0, fdas_pkg::OFS_MFR, 32'h0);
      chk(rdata, fdas_pkg::MFR_ID_DEF);
      wb(1'b0, fdas_pkg::OFS_DEV, 32'h0);
      chk(rdata, fdas_pkg::DEV_ID_DEF);
      wb(1'b0, fdas_pkg::OFS_SERIAL, 32'h0);
      chk(rdata, fdas_pkg::SERIAL_DEF);
      chk(32'(exp_wr.size()), 32'h0);
      end_of_test();
   end
endmodule
